/* dv/scr_config_regs_assertions.sv */
// port assertions of the configuration register group
`timescale 1ns/1ps
`default_nettype none
module scr_config_regs_assertions (
  input wire logic              core_clk,
  input wire logic              nrst,
  input wire scr_pkg::scrPins_t spiPins,
  input wire logic              sdo,
  input wire logic              sdoOe,
  input wire logic              deviceResetReq,
  input wire logic              powerDown,
  input wire logic              addressOrderUp,
  input wire logic              addressFreeze
);
  import scr_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  a_reset_window: assert property (
    $rose(deviceResetReq) |-> ##149 deviceResetReq ##1 !deviceResetReq)
    else $error("reset window length");
  a_reset_defaults: assert property (
    deviceResetReq |-> addressOrderUp && !powerDown && !addressFreeze)
    else $error("reset defaults");
  a_reset_no_read: assert property (deviceResetReq |-> !sdoOe)
    else $error("read during reset");
  a_order_change: assert property (
    $changed(addressOrderUp) |-> !spiPins.csN || $rose(deviceResetReq))
    else $error("order bit outside frame");
  a_mode_change: assert property (
    $changed(powerDown) |-> !spiPins.csN || $rose(deviceResetReq))
    else $error("power down outside frame");
  a_freeze_change: assert property (
    $changed(addressFreeze) |-> !spiPins.csN || $rose(deviceResetReq))
    else $error("freeze outside frame");
  a_sdo_quiet: assert property (!sdoOe |-> !sdo)
    else $error("sdo not quiet");
  a_oe_in_frame: assert property (sdoOe |-> !$past(spiPins.csN, 4))
    else $error("sdo driven outside frame");
endmodule
`default_nettype wire

/* dv/scr_spi_host.sv */
// serial host model framing mode-0 transfers
`timescale 1ns/1ps
`default_nettype none
module scr_spi_host (
  input  wire logic             core_clk,
  input  wire logic             sdo,
  output var scr_pkg::scrPins_t pins
);
  import scr_pkg::*;
  // six core cycles a phase stays clear of the four-cycle synchroniser minimum
  localparam int PH = 6;
  initial pins = '{sclk: 1'b0, csN: 1'b1, sdi: 1'b0};
  task automatic frame(input logic rw, input logic [14:0] a, input int nb,
                       input logic [31:0] wd, output logic [31:0] rdat);
    logic [47:0] sh;
    sh = {rw, a, wd};
    rdat = '0;
    @(posedge core_clk);
    pins.csN <= 1'b0;
    repeat (PH) @(posedge core_clk);
    for (int i = 0; i < 16 + 8 * nb; i++) begin
      pins.sdi <= sh[47-i];
      repeat (PH) @(posedge core_clk);
      if (i >= 16) rdat = {rdat[30:0], sdo};
      pins.sclk <= 1'b1;
      repeat (PH) @(posedge core_clk);
      pins.sclk <= 1'b0;
    end
    repeat (PH) @(posedge core_clk);
    pins.csN <= 1'b1;
    // released line flips so a stale bit is never mistaken for data
    pins.sdi <= ~pins.sdi;
    repeat (2 * PH) @(posedge core_clk);
  endtask
endmodule
`default_nettype wire

/* dv/testbench.sv */
// self-checking bench for the configuration register group
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import scr_pkg::*;
  localparam logic [3:0]  CLS = 4'h9;     // arbitrary value
  localparam logic [15:0] PID = 16'h5A3C; // arbitrary value
  localparam logic [7:0]  REV = 8'h42;    // arbitrary value
  localparam logic [15:0] MK  = 16'h7E61; // arbitrary value
  logic     core_clk = 1'b0;
  logic     nrst = 1'b0;
  scrPins_t pins;
  logic     sdo, sdoOe, rstReq, pd, up, frz;
  int       fails = 0;
  int       nCompared = 0;
  always #2.5 core_clk = ~core_clk;
  scr_spi_host host (.core_clk(core_clk), .sdo(sdo), .pins(pins));
  scr_config_regs #(.DEVICE_CLASS(CLS), .PART_ID(PID), .REVISION(REV), .MAKER_CODE(MK)) dut (
    .core_clk(core_clk), .nrst(nrst), .spiPins(pins), .sdo(sdo), .sdoOe(sdoOe),
    .deviceResetReq(rstReq), .powerDown(pd), .addressOrderUp(up), .addressFreeze(frz));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    logic [31:0] r;
    host.frame(1'b0, a, 1, {d, 24'h0}, r);
  endtask
  task automatic rd(input logic [14:0] a, input int n, output logic [31:0] r);
    host.frame(1'b1, a, n, 32'h0, r);
  endtask
  task automatic printVerdict;
    $display("compared %0d mismatches %0d", nCompared, fails);
    if (fails == 0 && nCompared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge core_clk);
    fails++;
    printVerdict;
  end
  initial begin
    logic [31:0] r;
    repeat (16) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (8) @(posedge core_clk);
    rd(ADDR_IF_SETUP, 1, r);
    chk(r, 32'h30);
    chk(32'(sdoOe), 32'h0);
    rd(ADDR_DEV_CLASS, 4, r);
    chk(r, {4'h0, CLS, PID[7:0], PID[15:8], REV});
    rd(ADDR_MAKER_LO, 2, r);
    chk(r, {16'h0, MK[7:0], MK[15:8]});
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_POWER_MODE, 8'hFC | 8'(m));
      chk(32'(pd), 32'(m[1]));
      rd(ADDR_POWER_MODE, 1, r);
      chk(r, 32'(m));
    end
    wr(ADDR_POWER_MODE, 8'h00);
    wr(ADDR_IF_SETUP, 8'h5F);
    chk(32'(up), 32'h0);
    rd(ADDR_IF_SETUP, 1, r);
    chk(r, 32'h10);
    rd(ADDR_REVISION, 2, r);
    chk(r, {16'h0, REV, PID[15:8]});
    wr(ADDR_FREEZE, 8'h01);
    wr(ADDR_DEV_CLASS, 8'hFF);
    rd(ADDR_DEV_CLASS, 2, r);
    chk(r, {16'h0, 4'h0, CLS, 4'h0, CLS});
    wr(ADDR_IF_SETUP, 8'h80);
    chk(32'(rstReq), 32'h1);
    repeat (200) @(posedge core_clk);
    chk(32'(rstReq), 32'h0);
    chk({29'h0, up, frz, pd}, 32'h4);
    rd(ADDR_IF_SETUP, 1, r);
    chk(r, 32'h30);
    printVerdict;
  end
endmodule
bind scr_config_regs scr_config_regs_assertions sva (.core_clk(core_clk), .nrst(nrst),
  .spiPins(spiPins), .sdo(sdo), .sdoOe(sdoOe), .deviceResetReq(deviceResetReq),
  .powerDown(powerDown), .addressOrderUp(addressOrderUp), .addressFreeze(addressFreeze));
`default_nettype wire

/* rtl/scr_config_regs.sv */
// standard configuration and identification registers behind a 4-wire serial port
`timescale 1ns/1ps
`default_nettype none
module scr_config_regs
  import scr_pkg::*;
#(
  parameter logic [3:0]  DEVICE_CLASS = 4'h5,     // arbitrary value
  parameter logic [15:0] PART_ID      = 16'h1234, // arbitrary value
  parameter logic [7:0]  REVISION     = 8'h01,    // arbitrary value
  parameter logic [15:0] MAKER_CODE   = 16'hABCD  // arbitrary value
) (
  input  wire logic               core_clk,
  input  wire logic               nrst,
  input  wire scr_pkg::scrPins_t  spiPins,
  output logic                    sdo,
  output logic                    sdoOe,
  output logic                    deviceResetReq,
  output logic                    powerDown,
  output logic                    addressOrderUp,
  output logic                    addressFreeze
);
  import scr_pkg::*;

  scrPins_t         pinsS;
  logic             sclkPrev;
  logic             csPrev;
  scrState_t        state;
  logic [4:0]       bitCnt;
  logic [14:0]      instrShift;
  logic [6:0]       wrShift;
  logic             isRead;
  logic [14:0]      addr;
  logic [7:0]       rdByte;
  logic [1:0]       powerMode;
  logic [7:0]       resetCnt;

  scr_sync #(
    .WIDTH (3)
  ) u_sync (
    .core_clk (core_clk),
    .nrst     (nrst),
    .asyncIn  (spiPins),
    .syncOut  (pinsS)
  );

  wire sclkRise   = pinsS.sclk & ~sclkPrev;
  wire sclkFall   = ~pinsS.sclk & sclkPrev;
  wire csFall     = csPrev & ~pinsS.csN;
  wire instrDone  = (state == ST_INSTR) && sclkRise && (bitCnt == 5'(INSTR_BITS - 1));
  wire byteDone   = (state == ST_DATA) && sclkRise && (bitCnt == 5'd7);
  wire [14:0] instrAddr = {instrShift[13:0], pinsS.sdi};

  // freeze overrides the stepping direction
  wire [14:0] nextAddr = addressFreeze  ? addr :
                         addressOrderUp ? 15'(addr + 15'h0001) :
                                          15'(addr - 15'h0001);

  wire        wrEn   = byteDone && !isRead;
  wire [7:0]  wrData = {wrShift, pinsS.sdi};
  wire        softHit = wrEn && (addr == ADDR_IF_SETUP) && wrData[SOFT_RESET_BIT];
  wire        regClear = !nrst || softHit;
  // counter runs from zero, so the window lasts exactly the full count
  wire        resetDone = (resetCnt == 8'(SOFT_RESET_CYCLES - 1));

  // only the writable fields have storage; fixed bits come from constants
  wire [7:0] ifSetupRead = {1'b0, 1'b0, addressOrderUp, 1'b1, 4'h0};

  wire [14:0] muxAddr = (state == ST_INSTR) ? instrAddr : nextAddr;
  wire [7:0]  muxData = (muxAddr == ADDR_IF_SETUP)   ? ifSetupRead :
                        (muxAddr == ADDR_POWER_MODE) ? {6'h00, powerMode} :
                        (muxAddr == ADDR_DEV_CLASS)  ? {4'h0, DEVICE_CLASS} :
                        (muxAddr == ADDR_PART_ID_LO) ? PART_ID[7:0] :
                        (muxAddr == ADDR_PART_ID_HI) ? PART_ID[15:8] :
                        (muxAddr == ADDR_REVISION)   ? REVISION :
                        (muxAddr == ADDR_MAKER_LO)   ? MAKER_CODE[7:0] :
                        (muxAddr == ADDR_MAKER_HI)   ? MAKER_CODE[15:8] :
                        (muxAddr == ADDR_FREEZE)     ? {7'h00, addressFreeze} :
                                                       8'h00;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      sclkPrev <= 1'b0;
      // the synchroniser resets low, so no select edge counts until csN was seen high
      csPrev   <= 1'b0;
    end else begin
      sclkPrev <= pinsS.sclk;
      csPrev   <= pinsS.csN;
    end
  end

  // writable configuration; a soft reset returns it to defaults
  always_ff @(posedge core_clk) begin
    if (regClear) begin
      addressOrderUp <= IF_SETUP_RESET[ADDR_ORDER_BIT];
      powerMode      <= POWER_MODE_RESET;
      addressFreeze  <= FREEZE_RESET;
    end else if (wrEn && (addr == ADDR_IF_SETUP)) begin
      addressOrderUp <= wrData[ADDR_ORDER_BIT];
    end else if (wrEn && (addr == ADDR_POWER_MODE)) begin
      powerMode <= wrData[1:0];
    end else if (wrEn && (addr == ADDR_FREEZE)) begin
      addressFreeze <= wrData[FREEZE_BIT];
    end
  end

  // codes 2 and 3 both have bit 1 set; 0 and 1 stay at full power
  assign powerDown = powerMode[POWER_DOWN_BIT];

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state <= ST_IDLE;
    end else if (softHit) begin
      state <= ST_RESET;
    end else if (pinsS.csN && (state != ST_RESET)) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          // a frame must start with a fresh select edge, never mid-frame
          if (csFall) begin
            state <= ST_INSTR;
          end
        end
        ST_INSTR: begin
          if (instrDone) begin
            state <= ST_DATA;
          end
        end
        ST_DATA: begin
          state <= ST_DATA;
        end
        ST_RESET: begin
          // transactions during the reset window are dropped
          if (resetDone) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst || state != ST_RESET) begin
      resetCnt <= 8'h00;
    end else begin
      resetCnt <= 8'(resetCnt + 8'h01);
    end
  end

  assign deviceResetReq = (state == ST_RESET);

  always_ff @(posedge core_clk) begin
    if (!nrst || state == ST_IDLE || state == ST_RESET) begin
      bitCnt <= 5'h00;
    end else if (instrDone || byteDone) begin
      bitCnt <= 5'h00;
    end else if (sclkRise) begin
      bitCnt <= 5'(bitCnt + 5'h01);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      instrShift <= 15'h0000;
      wrShift    <= 7'h00;
    end else if (sclkRise && state == ST_INSTR) begin
      instrShift <= instrAddr;
    end else if (sclkRise && state == ST_DATA) begin
      wrShift <= wrData[6:0];
    end
  end

  // address and read byte advance at each byte boundary
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      isRead <= 1'b0;
      addr   <= 15'h0000;
      rdByte <= 8'h00;
    end else if (instrDone) begin
      isRead <= instrShift[14];
      addr   <= instrAddr;
      rdByte <= muxData;
    end else if (byteDone) begin
      addr   <= nextAddr;
      rdByte <= muxData;
    end
  end

  // output bits change on the falling clock so the host samples them stable
  // clearing on the synced select rise keeps sdo low once the enable has dropped
  always_ff @(posedge core_clk) begin
    if (!nrst || state != ST_DATA || pinsS.csN) begin
      sdo <= 1'b0;
    end else if (sclkFall && isRead) begin
      sdo <= rdByte[3'(3'd7 - bitCnt[2:0])];
    end
  end

  // enable follows the state so it drops in the cycle sdo is cleared;
  // the short overlap after the select rises is harmless on a 4-wire bus
  assign sdoOe = (state == ST_DATA) && isRead;

endmodule
`default_nettype wire

/* rtl/scr_pkg.sv */
// shared constants and types of the serial configuration register group
package scr_pkg;

  localparam int unsigned    ADDR_W            = 15;
  localparam int unsigned    INSTR_BITS        = 16;

  localparam logic [14:0]    ADDR_IF_SETUP     = 15'h000;
  localparam logic [14:0]    ADDR_POWER_MODE   = 15'h002;
  localparam logic [14:0]    ADDR_DEV_CLASS    = 15'h003;
  localparam logic [14:0]    ADDR_PART_ID_LO   = 15'h004;
  localparam logic [14:0]    ADDR_PART_ID_HI   = 15'h005;
  localparam logic [14:0]    ADDR_REVISION     = 15'h006;
  localparam logic [14:0]    ADDR_MAKER_LO     = 15'h00C;
  localparam logic [14:0]    ADDR_MAKER_HI     = 15'h00D;
  localparam logic [14:0]    ADDR_FREEZE       = 15'h010;

  localparam int unsigned    SOFT_RESET_BIT    = 7;
  localparam int unsigned    ADDR_ORDER_BIT    = 5;
  localparam int unsigned    FOUR_WIRE_BIT     = 4;
  localparam int unsigned    FREEZE_BIT        = 0;
  localparam int unsigned    POWER_DOWN_BIT    = 1;

  localparam logic [7:0]     IF_SETUP_RESET    = 8'h30;
  localparam logic [1:0]     POWER_MODE_RESET  = 2'h0;
  localparam logic           FREEZE_RESET      = 1'b0;

  localparam int unsigned    CLK_PERIOD_PS     = 5000;
  localparam int unsigned    SOFT_RESET_NS     = 750;
  // rounded up so the window never ends before the quiet time has passed
  localparam int unsigned    SOFT_RESET_CYCLES =
    (SOFT_RESET_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  typedef struct packed {
    logic sclk;
    logic csN;
    logic sdi;
  } scrPins_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_INSTR = 2'b01,
    ST_DATA  = 2'b11,
    ST_RESET = 2'b10
  } scrState_t;

endpackage

/* rtl/scr_sync.sv */
// two-flop synchroniser for a bundle of asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module scr_sync #(
  parameter int unsigned WIDTH = 3
) (
  input  wire logic             core_clk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1;

  // stage1 is read only by syncOut
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      stage1  <= '0;
      syncOut <= '0;
    end else begin
      stage1  <= asyncIn;
      syncOut <= stage1;
    end
  end
endmodule
`default_nettype wire
